// *** verilog/sff_pkg.sv ***
/*
   Shared constants and types of the boot configuration and serial-flash
   fetch block: register offsets, field positions, reset values, flash
   opcodes, signature and timing counts.
   Assumes a 120 MHz core clock and an APB register bus with 32-bit data.
*/
package sff_pkg;

   // register byte offsets
   localparam logic [11:0] UTIL_CFG_OFS = 12'h000;
   localparam logic [11:0] FR_OPC_OFS = 12'h004;
   localparam logic [11:0] STRAP_OUT_OFS = 12'h008;
   localparam logic [11:0] STATUS_OFS = 12'h00C;

   // utility_config_reg fields and reset value
   localparam int UTIL_FLASH_OFF_BIT = 0;
   localparam int UTIL_DUAL_BIT = 1;
   localparam logic [1:0] UTIL_CFG_RST = 2'h0;

   // fast_read_opcode_reg reset value
   localparam logic [7:0] FR_OPC_RST = 8'h0B;

   // status register field positions
   localparam int STAT_SRC_POS = 0;
   localparam int STAT_DONE_POS = 2;
   localparam int STAT_EXT_POS = 3;
   localparam int STAT_BUSY_POS = 4;
   localparam int STAT_STRAP_POS = 16;

   // flash command stream
   localparam logic [7:0] OPC_FAST_READ = 8'h0B;
   localparam logic [5:0] CMD_BITS = 6'h20;
   localparam logic [5:0] DUMMY_CLKS = 6'h08;
   localparam logic [5:0] BYTE_CLKS_SINGLE = 6'h08;
   localparam logic [5:0] BYTE_CLKS_DUAL = 6'h04;
   localparam int DUAL_ADDR_BITS = 17;

   // boot signature "2DFU" read from this address on
   localparam logic [23:0] SIG_ADDR = 24'h00FFFA;
   localparam logic [31:0] SIG_VALUE = 32'h32444655;
   localparam logic [1:0] SIG_LAST_IDX = 2'h3;

   // flash clock: half periods in core cycles, slow rate scaled from fast
   localparam int FLASH_SLOW_MHZ = 30;
   localparam int FLASH_FAST_MHZ = 60;
   localparam int HALF_FAST = 1;
   localparam int HALF_SLOW = HALF_FAST * FLASH_FAST_MHZ / FLASH_SLOW_MHZ;

   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_FLASH,
      SRC_SMBUS,
      SRC_DEFAULT
   } sff_src_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SEND,
      ST_DUMMY,
      ST_DATA,
      ST_CATCH,
      ST_HOLD
   } sff_state_type;

endpackage : sff_pkg

// *** verilog/sff_top.sv ***
/*
   Boot configuration selection and automatic serial-flash fetch engine.
   Latches straps at reset release, probes the flash for a signature,
   picks the configuration source and serves processor byte reads in
   single or dual fast-read mode, with an APB register slave.
   Assumes: processor holds i_fetch_req until o_fetch_ready; flash pins
   and straps are asynchronous and pass two flip-flops.

// Function
// - flash present: configuration comes from flash
// - else management bus may configure device
// - else built-in defaults with strap overrides
// - straps high impedance during reset, driven after
// - strap levels captured at reset release
// - port off only when both straps high
// - rate strap low slow, high fast clock
// - suspend: rate pin floats if one, else low
// - boot reads signature 2DFU at 0xFFFA
// - valid signature enables flash, else internal ROM
// - flash enabled after reset; software bit disables
// - code read: chip enable low, 0x0B, address
// - single mode: dummy byte, eight data clocks
// - full byte received: ready plus data
// - sequential address: keep enable, one more byte
// - non-sequential address: enable high, new command
// - dual data reads use programmed opcode register
// - dual address: upper bits zero, low seventeen
// - dual mode: four clocks per data byte
// - dual mode samples both data lines
*/
module sff_top #(
   parameter int N_PORTS = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [2*N_PORTS:0] i_strap_pin,
   output logic [2*N_PORTS:0] o_strap_out,
   output logic [2*N_PORTS:0] o_strap_oe,
   input wire logic i_suspend,
   input wire logic i_smbus_present,
   output logic [N_PORTS-1:0] o_port_disable,
   output logic o_flash_rate_fast,
   output sff_pkg::sff_src_type o_cfg_source,
   output logic o_smbus_cfg_en,
   output logic o_boot_done,
   output logic o_boot_ext,
   input wire logic i_fetch_req,
   input wire logic i_fetch_data_space,
   input wire logic [23:0] i_fetch_addr,
   output logic o_fetch_ready,
   output logic [7:0] o_fetch_data,
   output logic o_flash_sclk,
   output logic o_flash_cs_n,
   output logic o_flash_mosi,
   output logic o_flash_mosi_oe,
   input wire logic i_flash_mosi_in,
   input wire logic i_flash_serial_in
);

   localparam int NS = 2 * N_PORTS + 1;
   localparam int RATE = 2 * N_PORTS;

   // synchronisers: first stage feeds only the second
   logic [NS-1:0] strap_m;
   logic [NS-1:0] strap_s;
   logic [1:0] misc_m;
   logic [1:0] misc_s;
   logic [1:0] fl_m;
   logic [1:0] fl_s;

   logic strap_taken;
   logic [NS-1:0] strap_lat;

   logic [1:0] util_cfg;
   logic [7:0] fr_opcode;
   logic [NS-1:0] strap_out_reg;
   logic acc;
   logic hit;
   logic [31:0] rd_word;

   sff_pkg::sff_state_type state;
   logic [3:0] hcnt;
   logic [3:0] half;
   logic tick;
   logic [5:0] rises;
   logic [31:0] tx_sr;
   logic [7:0] rx_sr;
   logic [2:0] samp_pipe;
   logic rise_data;
   logic [23:0] last_addr;
   logic cur_dual;
   logic byte_done;
   logic kill;

   logic boot_started;
   logic boot_busy;
   logic [1:0] boot_idx;
   logic [23:0] sig_sr;

   logic ext_ok;
   logic req_v;
   logic req_dual;
   logic [23:0] req_a;
   logic [7:0] req_opc;

   always_ff @(posedge i_clk_sys) begin
      strap_m <= i_strap_pin;
      strap_s <= strap_m;
      misc_m <= {i_suspend, i_smbus_present};
      misc_s <= misc_m;
      fl_m <= {i_flash_serial_in, i_flash_mosi_in};
      fl_s <= fl_m;
   end

   // straps are caught once, in the first cycle after release
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         strap_taken <= 1'b0;
         strap_lat <= '0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         strap_lat <= strap_s;
      end
   end

   // multi-function pins: floating in reset, outputs afterwards
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_strap_oe <= '0;
         o_strap_out <= '0;
      end else if (strap_taken) begin
         o_strap_oe <= {NS{1'b1}};
         o_strap_out <= strap_out_reg;
         if (misc_s[1]) begin
            o_strap_oe[RATE] <= ~strap_lat[RATE];
            o_strap_out[RATE] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_port_disable <= '0;
         o_flash_rate_fast <= 1'b0;
      end else if (strap_taken) begin
         o_port_disable <= strap_lat[N_PORTS-1:0] &
            strap_lat[2*N_PORTS-1:N_PORTS];
         o_flash_rate_fast <= strap_lat[RATE];
      end
   end

   // configuration source after the flash probe
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_cfg_source <= sff_pkg::SRC_NONE;
         o_smbus_cfg_en <= 1'b0;
      end else if (o_boot_done) begin
         o_smbus_cfg_en <= ~o_boot_ext & misc_s[0];
         if (o_boot_ext) begin
            o_cfg_source <= sff_pkg::SRC_FLASH;
         end else if (misc_s[0]) begin
            o_cfg_source <= sff_pkg::SRC_SMBUS;
         end else begin
            o_cfg_source <= sff_pkg::SRC_DEFAULT;
         end
      end
   end

   // APB slave: one wait state, answer on the second access cycle
   assign acc = i_psel & i_penable;

   always_comb begin
      hit = 1'b1;
      rd_word = '0;
      case (i_paddr)
         sff_pkg::UTIL_CFG_OFS: rd_word = 32'(util_cfg);
         sff_pkg::FR_OPC_OFS: rd_word = 32'(fr_opcode);
         sff_pkg::STRAP_OUT_OFS: rd_word = 32'(strap_out_reg);
         sff_pkg::STATUS_OFS: begin
            rd_word[sff_pkg::STAT_SRC_POS +: 2] = 2'(o_cfg_source);
            rd_word[sff_pkg::STAT_DONE_POS] = o_boot_done;
            rd_word[sff_pkg::STAT_EXT_POS] = o_boot_ext;
            rd_word[sff_pkg::STAT_BUSY_POS] = ~o_flash_cs_n;
            rd_word[sff_pkg::STAT_STRAP_POS +: NS] = strap_lat;
         end
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else begin
         o_pready <= acc & ~o_pready;
         if (acc & ~o_pready) begin
            o_pslverr <= ~hit;
            o_prdata <= i_pwrite ? 32'h00000000 : rd_word;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         util_cfg <= sff_pkg::UTIL_CFG_RST;
         fr_opcode <= sff_pkg::FR_OPC_RST;
         strap_out_reg <= '0;
      end else if (acc & o_pready & i_pwrite) begin
         case (i_paddr)
            sff_pkg::UTIL_CFG_OFS: util_cfg <= i_pwdata[1:0];
            sff_pkg::FR_OPC_OFS: fr_opcode <= i_pwdata[7:0];
            sff_pkg::STRAP_OUT_OFS: strap_out_reg <= i_pwdata[NS-1:0];
            default: ;
         endcase
      end
   end

   // request source: the boot probe first, the processor afterwards
   always_comb begin
      ext_ok = o_boot_ext & ~util_cfg[sff_pkg::UTIL_FLASH_OFF_BIT];
      req_v = boot_busy | (i_fetch_req & ext_ok & ~o_fetch_ready);
      req_dual = ~boot_busy & i_fetch_data_space &
         util_cfg[sff_pkg::UTIL_DUAL_BIT];
      req_opc = req_dual ? fr_opcode : sff_pkg::OPC_FAST_READ;
      if (boot_busy) begin
         req_a = sff_pkg::SIG_ADDR + 24'(boot_idx);
      end else if (req_dual) begin
         req_a = {7'h00, i_fetch_addr[sff_pkg::DUAL_ADDR_BITS-1:0]};
      end else begin
         req_a = i_fetch_addr;
      end
      kill = util_cfg[sff_pkg::UTIL_FLASH_OFF_BIT] & ~boot_busy;
      half = o_flash_rate_fast ? 4'(sff_pkg::HALF_FAST - 1) :
         4'(sff_pkg::HALF_SLOW - 1);
      tick = (hcnt == 4'h0);
      rise_data = (state == sff_pkg::ST_DATA) & tick & ~o_flash_sclk;
   end

   // data sample lands three cycles after the rising edge is issued
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         samp_pipe <= '0;
         rx_sr <= '0;
      end else begin
         samp_pipe <= {samp_pipe[1:0], rise_data};
         if (samp_pipe[2]) begin
            if (cur_dual) begin
               rx_sr <= {rx_sr[5:0], fl_s[1], fl_s[0]};
            end else begin
               rx_sr <= {rx_sr[6:0], fl_s[1]};
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         state <= sff_pkg::ST_IDLE;
         o_flash_cs_n <= 1'b1;
         o_flash_sclk <= 1'b0;
         o_flash_mosi <= 1'b0;
         o_flash_mosi_oe <= 1'b0;
         o_fetch_ready <= 1'b0;
         o_fetch_data <= '0;
         byte_done <= 1'b0;
         hcnt <= '0;
         rises <= '0;
         tx_sr <= '0;
         last_addr <= '0;
         cur_dual <= 1'b0;
      end else begin
         o_fetch_ready <= 1'b0;
         byte_done <= 1'b0;
         if (kill && state != sff_pkg::ST_IDLE) begin
            state <= sff_pkg::ST_IDLE;
            o_flash_cs_n <= 1'b1;
            o_flash_sclk <= 1'b0;
            o_flash_mosi_oe <= 1'b0;
         end else begin
            case (state)
               sff_pkg::ST_IDLE: begin
                  o_flash_cs_n <= 1'b1;
                  o_flash_mosi_oe <= 1'b0;
                  if (req_v & o_flash_cs_n & strap_taken & ~kill) begin
                     o_flash_cs_n <= 1'b0;
                     o_flash_mosi_oe <= 1'b1;
                     o_flash_mosi <= req_opc[7];
                     tx_sr <= {req_opc[6:0], req_a, 1'b0};
                     rises <= sff_pkg::CMD_BITS;
                     hcnt <= half;
                     last_addr <= req_a;
                     cur_dual <= req_dual;
                     state <= sff_pkg::ST_SEND;
                  end else if (o_boot_done & ~ext_ok & i_fetch_req &
                        ~o_fetch_ready) begin
                     // no usable flash: answer at once with erased data
                     o_fetch_ready <= 1'b1;
                     o_fetch_data <= 8'hFF;
                  end
               end
               sff_pkg::ST_SEND, sff_pkg::ST_DUMMY,
               sff_pkg::ST_DATA: begin
                  if (!tick) begin
                     hcnt <= hcnt - 4'h1;
                  end else begin
                     hcnt <= half;
                     o_flash_sclk <= ~o_flash_sclk;
                     if (!o_flash_sclk) begin
                        rises <= rises - 6'h01;
                     end else if (rises != 6'h00) begin
                        if (state == sff_pkg::ST_SEND) begin
                           o_flash_mosi <= tx_sr[31];
                           tx_sr <= {tx_sr[30:0], 1'b0};
                        end
                     end else begin
                        case (state)
                           sff_pkg::ST_SEND: begin
                              o_flash_mosi <= 1'b0;
                              rises <= sff_pkg::DUMMY_CLKS;
                              // dual read turns the out line around
                              o_flash_mosi_oe <= ~cur_dual;
                              state <= sff_pkg::ST_DUMMY;
                           end
                           sff_pkg::ST_DUMMY: begin
                              rises <= cur_dual ?
                                 sff_pkg::BYTE_CLKS_DUAL :
                                 sff_pkg::BYTE_CLKS_SINGLE;
                              state <= sff_pkg::ST_DATA;
                           end
                           default: state <= sff_pkg::ST_CATCH;
                        endcase
                     end
                  end
               end
               sff_pkg::ST_CATCH: begin
                  if (samp_pipe == 3'h0) begin
                     o_fetch_data <= rx_sr;
                     o_fetch_ready <= ~boot_busy;
                     byte_done <= 1'b1;
                     state <= sff_pkg::ST_HOLD;
                  end
               end
               sff_pkg::ST_HOLD: begin
                  if (byte_done | o_fetch_ready) begin
                     state <= sff_pkg::ST_HOLD;
                  end else if (req_v) begin
                     if (req_a == last_addr + 24'h000001 &&
                           req_dual == cur_dual) begin
                        rises <= cur_dual ? sff_pkg::BYTE_CLKS_DUAL :
                           sff_pkg::BYTE_CLKS_SINGLE;
                        hcnt <= half;
                        last_addr <= req_a;
                        state <= sff_pkg::ST_DATA;
                     end else begin
                        o_flash_cs_n <= 1'b1;
                        o_flash_mosi_oe <= 1'b0;
                        state <= sff_pkg::ST_IDLE;
                     end
                  end else if (~boot_busy & ~ext_ok) begin
                     o_flash_cs_n <= 1'b1;
                     o_flash_mosi_oe <= 1'b0;
                     state <= sff_pkg::ST_IDLE;
                  end
               end
               default: state <= sff_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // boot probe: four signature bytes, then the execution source
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         boot_started <= 1'b0;
         boot_busy <= 1'b0;
         boot_idx <= '0;
         sig_sr <= '0;
         o_boot_done <= 1'b0;
         o_boot_ext <= 1'b0;
      end else begin
         if (strap_taken & ~boot_started) begin
            boot_started <= 1'b1;
            boot_busy <= 1'b1;
         end
         if (boot_busy & byte_done) begin
            sig_sr <= {sig_sr[15:0], o_fetch_data};
            boot_idx <= boot_idx + 2'h1;
            if (boot_idx == sff_pkg::SIG_LAST_IDX) begin
               boot_busy <= 1'b0;
               o_boot_done <= 1'b1;
               o_boot_ext <= ({sig_sr, o_fetch_data} ==
                  sff_pkg::SIG_VALUE);
            end
         end
      end
   end

endmodule : sff_top

// *** tb/sff_flash_model.sv ***
/*
   Serial flash model answering fast reads, 0x0B single and 0x3B dual.
   Assumes mode 0 clocking and a chip enable that frames each command.
*/
module sff_flash_model (
   input wire logic i_clk,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_io0,
   input wire logic i_sig_good,
   output logic o_io0,
   output logic o_io1
);
   timeunit 1ns;
   timeprecision 1ns;
   int nrise = 0;
   int k;
   logic [31:0] cmd;
   logic [7:0] b;
   logic dual;
   initial begin
      o_io0 = 1'b0;
      o_io1 = 1'b0;
   end
   function automatic logic [7:0] mem_byte(input logic [23:0] a,
         input logic good);
      if (good && a == 24'h00FFFA) return 8'h32;
      if (good && a == 24'h00FFFB) return 8'h44;
      if (good && a == 24'h00FFFC) return 8'h46;
      if (good && a == 24'h00FFFD) return 8'h55;
      return a[7:0] ^ a[15:8] ^ 8'hC3;
   endfunction : mem_byte
   always @(negedge i_cs_n) nrise = 0;
   always @(posedge i_sclk) begin
      if (!i_cs_n) begin
         if (nrise < 32) cmd = {cmd[30:0], i_io0};
         nrise++;
      end
   end
   // data changes after a fall so it is steady at the next rise
   always @(negedge i_sclk) begin
      if (!i_cs_n && nrise >= 40) begin
         k = nrise - 40;
         dual = (cmd[31:24] == 8'h3B);
         b = mem_byte(cmd[23:0] + 24'(dual ? k / 4 : k / 8), i_sig_good);
         if (dual) begin
            o_io1 <= b[7 - 2 * (k % 4)];
            o_io0 <= b[6 - 2 * (k % 4)];
         end else begin
            o_io1 <= b[7 - k % 8];
         end
      end
   end
   // released lines toggle so a stale bit can never pass as data
   always @(posedge i_clk) begin
      if (i_cs_n || nrise < 40) begin
         o_io0 <= ~o_io0;
         o_io1 <= ~o_io1;
      end
   end
endmodule : sff_flash_model

// *** tb/sff_top_chk.sv ***
/*
   Port assertions for the boot configuration and flash fetch block.
   Assumes one clock domain and straps held steady around reset release.
*/
module sff_top_chk #(
   parameter int N_PORTS = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [2*N_PORTS:0] i_strap_pin,
   input wire logic [2*N_PORTS:0] o_strap_out,
   input wire logic [2*N_PORTS:0] o_strap_oe,
   input wire logic i_suspend,
   input wire logic [N_PORTS-1:0] o_port_disable,
   input wire logic o_flash_rate_fast,
   input wire logic o_boot_done,
   input wire logic i_fetch_req,
   input wire logic [23:0] i_fetch_addr,
   input wire logic o_fetch_ready,
   input wire logic o_flash_cs_n,
   input wire logic o_flash_mosi
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int S = 2 * N_PORTS;
   logic [S:0] lat;
   logic req_d;
   logic rdy_d;
   logic [23:0] last_a;
   logic new_req;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // pin levels as last seen while reset held the pins released
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) lat <= i_strap_pin;
   end
   always_ff @(posedge i_clk_sys) begin
      req_d <= i_fetch_req;
      rdy_d <= o_fetch_ready;
      if (o_fetch_ready) last_a <= i_fetch_addr;
   end
   assign new_req = i_fetch_req && (!req_d || rdy_d) && o_boot_done;
   sequence s_jump;
      new_req && !o_flash_cs_n && i_fetch_addr != last_a + 24'h1;
   endsequence
   sequence s_seq;
      new_req && !o_flash_cs_n && i_fetch_addr == last_a + 24'h1;
   endsequence
   sequence s_byte;
      1'b1 ##[1:300] o_fetch_ready;
   endsequence
   property p_rst;
      $rose(i_reset_n) |-> o_flash_cs_n && o_strap_oe == '0;
   endproperty
   a_rst: assert property (p_rst)
      else $error("flash enable or strap drive active in reset");
   property p_drive;
      $rose(i_reset_n) |-> ##[1:3] (&o_strap_oe);
   endproperty
   a_drive: assert property (p_drive)
      else $error("strap pins not driven after reset");
   property p_strap;
      o_boot_done |-> o_port_disable == (lat[N_PORTS-1:0] & lat[S-1:N_PORTS])
         && o_flash_rate_fast == lat[S];
   endproperty
   a_strap: assert property (p_strap)
      else $error("latched strap settings wrong");
   property p_susp;
      $rose(i_suspend) |-> ##[2:4] (o_strap_oe[S] != lat[S]
         && (lat[S] || !o_strap_out[S]));
   endproperty
   a_susp: assert property (p_susp)
      else $error("rate pin wrong in suspend");
   property p_first;
      $fell(o_flash_cs_n) |-> !o_flash_mosi [*4];
   endproperty
   a_first: assert property (p_first)
      else $error("opcode does not start with zero bits");
   property p_held;
      o_fetch_ready |-> i_fetch_req;
   endproperty
   a_held: assert property (p_held)
      else $error("ready without a pending request");
   property p_answer;
      new_req |-> s_byte;
   endproperty
   a_answer: assert property (p_answer)
      else $error("fetch not answered");
   property p_jump;
      s_jump |-> ##[0:4] o_flash_cs_n;
   endproperty
   a_jump: assert property (p_jump)
      else $error("jump did not end the transfer");
   property p_burst;
      s_seq |-> !o_flash_cs_n throughout s_byte;
   endproperty
   a_burst: assert property (p_burst)
      else $error("sequential fetch broke the burst");
endmodule : sff_top_chk

// *** tb/sff_top_tb.sv ***
/*
   Self-checking bench: three boot configurations, fetch bursts, dual
   reads, registers over APB. Assumes the flash model and the checker.
*/
module sff_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, sus = 1'b0, smb = 1'b0;
   logic req = 1'b0, ds = 1'b0, sig_good = 1'b1, dual = 1'b0, off = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'h7A1F6948;
   logic [8:0] strap = 9'h000, s_out, s_oe, s_pin;
   logic [23:0] addr = 24'h000000, a;
   logic [7:0] fdata;
   logic [3:0] pdis;
   logic pready, err, perr, rate, smb_en, done, ext, rdy;
   logic sclk, cs_n, mosi, moe, io0, f_io0, f_io1;
   sff_pkg::sff_src_type src, want;
   int bad_count = 0;
   int total_checks = 0;
   assign s_pin = (s_oe & s_out) | (~s_oe & strap);
   assign io0 = moe ? mosi : f_io0;
   always #25 clk = ~clk;
   sff_top sff_top_inst (
      .i_clk_sys(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(perr), .i_strap_pin(s_pin),
      .o_strap_out(s_out), .o_strap_oe(s_oe), .i_suspend(sus),
      .i_smbus_present(smb), .o_port_disable(pdis), .o_flash_rate_fast(rate),
      .o_cfg_source(src), .o_smbus_cfg_en(smb_en), .o_boot_done(done),
      .o_boot_ext(ext), .i_fetch_req(req), .i_fetch_data_space(ds),
      .i_fetch_addr(addr), .o_fetch_ready(rdy), .o_fetch_data(fdata),
      .o_flash_sclk(sclk), .o_flash_cs_n(cs_n), .o_flash_mosi(mosi),
      .o_flash_mosi_oe(moe), .i_flash_mosi_in(io0), .i_flash_serial_in(f_io1)
   );
   sff_flash_model sff_flash_model_inst (.i_clk(clk), .i_cs_n(cs_n),
      .i_sclk(sclk), .i_io0(io0), .i_sig_good(sig_good), .o_io0(f_io0),
      .o_io1(f_io1));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [7:0] exp_byte(input logic d, logic [23:0] fa);
      if (off || !sig_good) return 8'hFF;
      if (d && dual) fa = {7'h00, fa[16:0]};
      return sff_flash_model_inst.mem_byte(fa, 1'b1);
   endfunction : exp_byte
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: reg %h not %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: byte %h not %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic apb(input logic w, input logic [11:0] pa, logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= pa;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic fetch(input logic d, input logic [23:0] fa);
      logic [7:0] e;
      e = exp_byte(d, fa);
      @(posedge clk);
      req <= 1'b1;
      ds <= d;
      addr <= fa;
      do @(posedge clk); while (rdy !== 1'b1);
      req <= 1'b0;
      chk_byte(fdata, e);
   endtask : fetch
   task automatic tally_and_finish();
      if (bad_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         a = 24'(xs());
         rst_n <= 1'b0;
         sig_good <= (k == 0);
         smb <= (k != 2);
         strap <= {k[0], a[7:0]};
         dual = 1'b0;
         off = 1'b0;
         repeat (10) @(posedge clk);
         rst_n <= 1'b1;
         while (done !== 1'b1) @(posedge clk);
         // source and bus enable settle one edge after boot done
         @(posedge clk);
         want = k == 0 ? sff_pkg::SRC_FLASH : k == 1 ? sff_pkg::SRC_SMBUS
            : sff_pkg::SRC_DEFAULT;
         chk_reg({22'h0, &s_oe, pdis, rate, smb_en, ext, src},
            {22'h0, 1'b1, strap[3:0] & strap[7:4], strap[8], k == 1,
            k == 0, want});
         apb(1'b0, sff_pkg::STATUS_OFS, 32'h0);
         chk_reg(rd & ~32'h10,
            {7'h0, strap, 12'h0, k == 0, 1'b1, want});
         apb(1'b0, sff_pkg::UTIL_CFG_OFS, 32'h0);
         chk_reg(rd, {30'h0, sff_pkg::UTIL_CFG_RST});
         apb(1'b0, sff_pkg::FR_OPC_OFS, 32'h0);
         chk_reg(rd, {24'h0, sff_pkg::FR_OPC_RST});
         apb(1'b1, 12'h010, 32'hFFFFFFFF);
         apb(1'b0, 12'h010, 32'h0);
         chk_reg({rd[30:0], err}, 32'h1);
         sus <= 1'b1;
         repeat (6) @(posedge clk);
         chk_reg({30'h0, s_oe[8], s_out[8] & s_oe[8]},
            {30'h0, ~strap[8], 1'b0});
         sus <= 1'b0;
         repeat (6) @(posedge clk);
         fetch(1'b0, 24'h000000);
         if (k == 0) begin
            a = a & 24'h00FFF0;
            for (int i = 0; i < 4; i++)
               fetch(1'b0, a + 24'(i));
            fetch(1'b0, a + 24'h40);
            apb(1'b1, sff_pkg::FR_OPC_OFS, 32'h3B);
            apb(1'b1, sff_pkg::UTIL_CFG_OFS, 32'h2);
            dual = 1'b1;
            for (int i = 0; i < 2; i++)
               fetch(1'b1, 24'hFE0120 + 24'(i));
            fetch(1'b0, a);
            v = xs() & 32'h1FF;
            apb(1'b1, sff_pkg::STRAP_OUT_OFS, v);
            apb(1'b0, sff_pkg::STRAP_OUT_OFS, 32'h0);
            chk_reg(rd, v);
            chk_reg({23'h0, s_out}, {23'h0, v[8:0]});
            apb(1'b1, sff_pkg::UTIL_CFG_OFS, 32'h1);
            off = 1'b1;
            fetch(1'b0, a);
         end
      end
      tally_and_finish();
   end
endmodule : sff_top_tb
bind sff_top sff_top_chk #(.N_PORTS(N_PORTS)) sff_top_chk_inst (
   .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
   .i_strap_pin(i_strap_pin), .o_strap_out(o_strap_out),
   .o_strap_oe(o_strap_oe), .i_suspend(i_suspend),
   .o_port_disable(o_port_disable), .o_flash_rate_fast(o_flash_rate_fast),
   .o_boot_done(o_boot_done), .i_fetch_req(i_fetch_req),
   .i_fetch_addr(i_fetch_addr), .o_fetch_ready(o_fetch_ready),
   .o_flash_cs_n(o_flash_cs_n), .o_flash_mosi(o_flash_mosi)
);
